// ==== core/pib_pkg.sv ====
package pib_pkg;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PA_W = 6;
   localparam int unsigned PC_W = 2;
   localparam int unsigned PD_W = 8;
   localparam int unsigned SPI_W = 4;
   localparam int unsigned NARROW_W = 4;
   localparam int unsigned SYNC_W = PA_W + PC_W + PD_W;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_PA_DATA = 9'h000;
   localparam logic [ADDR_W-1:0] OFS_RSVD_ONE = 9'h001;
   localparam logic [ADDR_W-1:0] OFS_PA_DIR = 9'h002;
   localparam logic [ADDR_W-1:0] OFS_RSVD_THREE = 9'h003;
   localparam logic [ADDR_W-1:0] OFS_PC_DATA = 9'h004;
   localparam logic [ADDR_W-1:0] OFS_PD_DATA = 9'h005;
   localparam logic [ADDR_W-1:0] OFS_PC_DIR = 9'h006;
   localparam logic [ADDR_W-1:0] OFS_PD_DIR = 9'h007;
   localparam logic [ADDR_W-1:0] OFS_PA_PIN_IN = 9'h120;
   localparam logic [ADDR_W-1:0] OFS_RSVD_GAP = 9'h121;
   localparam logic [ADDR_W-1:0] OFS_PA_DRV_RED = 9'h122;

   // Pin positions
   localparam int unsigned POS_SPI_MISO = 0;
   localparam int unsigned POS_SPI_MOSI = 1;
   localparam int unsigned POS_SPI_SCK = 2;
   localparam int unsigned POS_SPI_SS = 3;
   localparam int unsigned POS_DL_CLK = 0;
   localparam int unsigned POS_DL_INT = 1;

   // Reset values
   localparam logic [PA_W-1:0] RST_PA = 6'h00;
   localparam logic [PC_W-1:0] RST_PC = 2'h0;
   localparam logic [PD_W-1:0] RST_PD = 8'h00;
   localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;
   localparam logic [SYNC_W-1:0] RST_SYNC = 16'h0000;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
endpackage

// ==== core/pib_top.sv ====
// Function
// - Each pin is general purpose I/O whenever its peripheral does not use it.
// - Peripheral function outranks general purpose I/O; selected source drives the pin.
// - Six-pin port A serves the serial peripheral interface as alternative.
// - Two-pin port C carries die link clock out and interrupt in.
// - Eight-pin port D carries die link data, eight or four bits, bidirectional.
// - Pull-downs on interrupt pin and data pins while they are link inputs.
// - Each port A pin output drive can be reduced by its own bit.
// - Data and direction registers exist for ports A, C and D.
// - Port A input register returns the port A pin levels.
// - Direction 1 reads stored data; otherwise synchronised pin level.
// - Port A bits 3..0 carry SS, SCK, MOSI, MISO under serial function.
// - Port A data register readable and writable at any time.
// - Direction 1 makes the pin output; 0 makes it high-impedance input.
// - Serial peripheral sets direction of owned pins; stored direction unchanged.
// - Port C bit 1 is link interrupt, bit 0 link clock.
// - Writes to reserved locations have no effect.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pib_top
   import pib_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   input wire logic i_spi_en,
   input wire logic [SPI_W-1:0] i_spi_out,
   input wire logic [SPI_W-1:0] i_spi_oe,
   output logic [SPI_W-1:0] o_spi_in,
   input wire logic i_dl_en,
   input wire logic i_dl_wide,
   input wire logic i_dl_clk,
   input wire logic [PD_W-1:0] i_dl_data_out,
   input wire logic i_dl_data_oe,
   output logic [PD_W-1:0] o_dl_data_in,
   output logic o_dl_int,
   input wire logic [PA_W-1:0] i_pa_in,
   output logic [PA_W-1:0] o_pa_out,
   output logic [PA_W-1:0] o_pa_oe,
   output logic [PA_W-1:0] o_pa_drv_reduce,
   input wire logic [PC_W-1:0] i_pc_in,
   output logic [PC_W-1:0] o_pc_out,
   output logic [PC_W-1:0] o_pc_oe,
   output logic [PC_W-1:0] o_pc_pulldown,
   input wire logic [PD_W-1:0] i_pd_in,
   output logic [PD_W-1:0] o_pd_out,
   output logic [PD_W-1:0] o_pd_oe,
   output logic [PD_W-1:0] o_pd_pulldown
);
   logic [PA_W-1:0] pa_data_r, pa_data_nxt;
   logic [PA_W-1:0] pa_dir_r, pa_dir_nxt;
   logic [PA_W-1:0] pa_red_r, pa_red_nxt;
   logic [PC_W-1:0] pc_data_r, pc_data_nxt;
   logic [PC_W-1:0] pc_dir_r, pc_dir_nxt;
   logic [PD_W-1:0] pd_data_r, pd_data_nxt;
   logic [PD_W-1:0] pd_dir_r, pd_dir_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [SYNC_W-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
   logic [SYNC_W-1:0] s1_nxt, s2_nxt, s3_nxt;
   logic [SYNC_W-1:0] pins_raw;
   logic [PA_W-1:0] pa_lvl;
   logic [PC_W-1:0] pc_lvl;
   logic [PD_W-1:0] pd_lvl;
   logic [PA_W-1:0] pa_spi_own;
   logic [PC_W-1:0] pc_dl_own;
   logic [PD_W-1:0] pd_dl_own;
   logic [PA_W-1:0] pa_rd_val;
   logic [PC_W-1:0] pc_rd_val;
   logic [PD_W-1:0] pd_rd_val;
   logic [SPI_W-1:0] spi_in_r, spi_in_nxt;
   logic dl_int_r, dl_int_nxt;
   logic [PD_W-1:0] dl_data_in_r, dl_data_in_nxt;

   // Three-stage input synchroniser; a level is taken when stages 2 and 3 agree
   assign pins_raw = {i_pd_in, i_pc_in, i_pa_in};

   always_comb
   begin
      s1_nxt = pins_raw;
      // Only the second stage reads the first, keeping metastability contained
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      for (int i = 0; i < SYNC_W; i++)
      begin
         filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s1_r <= RST_SYNC;
         s2_r <= RST_SYNC;
         s3_r <= RST_SYNC;
         filt_r <= RST_SYNC;
      end
      else
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         filt_r <= filt_nxt;
      end
   end

   assign pa_lvl = filt_r[PA_W-1:0];
   assign pc_lvl = filt_r[PA_W+PC_W-1:PA_W];
   assign pd_lvl = filt_r[SYNC_W-1:PA_W+PC_W];

   // Ownership of pins by the peripherals
   // Port A pins 5 and 4 never belong to the serial peripheral
   always_comb
   begin
      pa_spi_own = '0;
      pa_spi_own[SPI_W-1:0] = {SPI_W{i_spi_en}};
      pc_dl_own = {PC_W{i_dl_en}};
      pd_dl_own = '0;
      pd_dl_own[NARROW_W-1:0] = {NARROW_W{i_dl_en}};
      pd_dl_own[PD_W-1:NARROW_W] = {(PD_W-NARROW_W){i_dl_en & i_dl_wide}};
   end

   // Pin drive: peripheral first, register otherwise
   // Port A: the serial peripheral outranks the registers on pins 3..0
   always_comb
   begin
      for (int i = 0; i < PA_W; i++)
      begin
         if (pa_spi_own[i])
         begin
            o_pa_out[i] = i_spi_out[i[1:0]];
            o_pa_oe[i] = i_spi_oe[i[1:0]];
         end
         else
         begin
            o_pa_out[i] = pa_data_r[i];
            o_pa_oe[i] = pa_dir_r[i];
         end
      end
   end

   // Port C: the link drives the clock pin and listens on the interrupt pin
   always_comb
   begin
      o_pc_out = pc_data_r;
      o_pc_oe = pc_dir_r;
      if (pc_dl_own[POS_DL_CLK])
      begin
         o_pc_out[POS_DL_CLK] = i_dl_clk;
         o_pc_oe[POS_DL_CLK] = 1'h1;
      end
      if (pc_dl_own[POS_DL_INT])
      begin
         o_pc_out[POS_DL_INT] = 1'h0;
         o_pc_oe[POS_DL_INT] = 1'h0;
      end
   end

   // Port D: narrow mode hands pins 7..4 back to general purpose I/O
   always_comb
   begin
      for (int i = 0; i < PD_W; i++)
      begin
         if (pd_dl_own[i])
         begin
            o_pd_out[i] = i_dl_data_out[i];
            o_pd_oe[i] = i_dl_data_oe;
         end
         else
         begin
            o_pd_out[i] = pd_data_r[i];
            o_pd_oe[i] = pd_dir_r[i];
         end
      end
   end

   // Pull-downs only while a link pin listens
   // Narrow mode frees data pins 7..4, so their pull-downs drop too
   always_comb
   begin
      o_pc_pulldown = '0;
      o_pc_pulldown[POS_DL_INT] = pc_dl_own[POS_DL_INT];
      o_pd_pulldown = pd_dl_own & {PD_W{~i_dl_data_oe}};
   end

   assign o_pa_drv_reduce = pa_red_r;

   // Peripheral inputs from synchronised pin levels
   always_comb
   begin
      spi_in_nxt = pa_lvl[SPI_W-1:0] & pa_spi_own[SPI_W-1:0];
      dl_int_nxt = pc_lvl[POS_DL_INT] & pc_dl_own[POS_DL_INT];
      dl_data_in_nxt = pd_lvl & pd_dl_own;
   end

   // Registered so the peripherals only ever see flip-flop outputs
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         spi_in_r <= RST_SYNC[SPI_W-1:0];
         dl_int_r <= RST_SYNC[PA_W+POS_DL_INT];
         dl_data_in_r <= RST_SYNC[SYNC_W-1:PA_W+PC_W];
      end
      else
      begin
         spi_in_r <= spi_in_nxt;
         dl_int_r <= dl_int_nxt;
         dl_data_in_r <= dl_data_in_nxt;
      end
   end

   assign o_spi_in = spi_in_r;
   assign o_dl_int = dl_int_r;
   assign o_dl_data_in = dl_data_in_r;

   // Read-back values: stored data for outputs, pin level for inputs
   always_comb
   begin
      pa_rd_val = (pa_dir_r & pa_data_r) | (~pa_dir_r & pa_lvl);
      pc_rd_val = (pc_dir_r & pc_data_r) | (~pc_dir_r & pc_lvl);
      pd_rd_val = (pd_dir_r & pd_data_r) | (~pd_dir_r & pd_lvl);
   end

   // Register writes
   // The pin input register is read-only, so its offset falls to the default
   always_comb
   begin
      pa_data_nxt = pa_data_r;
      pa_dir_nxt = pa_dir_r;
      pa_red_nxt = pa_red_r;
      pc_data_nxt = pc_data_r;
      pc_dir_nxt = pc_dir_r;
      pd_data_nxt = pd_data_r;
      pd_dir_nxt = pd_dir_r;
      if (i_wr)
      begin
         case (i_addr)
            OFS_PA_DATA: pa_data_nxt = i_wdata[PA_W-1:0];
            OFS_PA_DIR: pa_dir_nxt = i_wdata[PA_W-1:0];
            OFS_PC_DATA: pc_data_nxt = i_wdata[PC_W-1:0];
            OFS_PD_DATA: pd_data_nxt = i_wdata[PD_W-1:0];
            OFS_PC_DIR: pc_dir_nxt = i_wdata[PC_W-1:0];
            OFS_PD_DIR: pd_dir_nxt = i_wdata[PD_W-1:0];
            OFS_PA_DRV_RED: pa_red_nxt = i_wdata[PA_W-1:0];
            default: ;
         endcase
      end
   end

   // Read data, valid in the cycle after the strobe only
   // Upper bits beyond a register's width stay at the zero default
   always_comb
   begin
      rdata_nxt = READ_ZERO;
      if (i_rd)
      begin
         case (i_addr)
            OFS_PA_DATA: rdata_nxt[PA_W-1:0] = pa_rd_val;
            OFS_PA_DIR: rdata_nxt[PA_W-1:0] = pa_dir_r;
            OFS_PC_DATA: rdata_nxt[PC_W-1:0] = pc_rd_val;
            OFS_PD_DATA: rdata_nxt[PD_W-1:0] = pd_rd_val;
            OFS_PC_DIR: rdata_nxt[PC_W-1:0] = pc_dir_r;
            OFS_PD_DIR: rdata_nxt[PD_W-1:0] = pd_dir_r;
            OFS_PA_PIN_IN: rdata_nxt[PA_W-1:0] = pa_lvl;
            OFS_PA_DRV_RED: rdata_nxt[PA_W-1:0] = pa_red_r;
            default: rdata_nxt = READ_ZERO;
         endcase
      end
   end

   // Port registers start at zero; read data idles at zero between reads
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         pa_data_r <= RST_PA;
         pa_dir_r <= RST_PA;
         pa_red_r <= RST_PA;
         pc_data_r <= RST_PC;
         pc_dir_r <= RST_PC;
         pd_data_r <= RST_PD;
         pd_dir_r <= RST_PD;
         rdata_r <= RST_RDATA;
      end
      else
      begin
         pa_data_r <= pa_data_nxt;
         pa_dir_r <= pa_dir_nxt;
         pa_red_r <= pa_red_nxt;
         pc_data_r <= pc_data_nxt;
         pc_dir_r <= pc_dir_nxt;
         pd_data_r <= pd_data_nxt;
         pd_dir_r <= pd_dir_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;
endmodule
`default_nettype wire

// ==== sim/pib_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module pib_top_asserts
   import pib_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic i_spi_en,
   input wire logic [SPI_W-1:0] i_spi_out,
   input wire logic [SPI_W-1:0] i_spi_oe,
   input wire logic i_dl_en,
   input wire logic i_dl_wide,
   input wire logic i_dl_data_oe,
   input wire logic [PA_W-1:0] o_pa_out,
   input wire logic [PA_W-1:0] o_pa_oe,
   input wire logic [PA_W-1:0] o_pa_drv_reduce,
   input wire logic [PC_W-1:0] o_pc_oe,
   input wire logic [PC_W-1:0] o_pc_pulldown,
   input wire logic [PD_W-1:0] o_pd_pulldown
);
   logic rsvd;
   assign rsvd = i_addr inside {OFS_RSVD_ONE, OFS_RSVD_THREE, OFS_RSVD_GAP};
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not idle");
   AST_RSVD: assert property (i_rd && rsvd |=> o_rdata == 8'h00)
      else $error("reserved read not zero");
   AST_DIR_OE:
      assert property ($past(i_wr && i_addr == OFS_PA_DIR) && !i_spi_en
         |-> o_pa_oe == $past(i_wdata[PA_W-1:0])) else $error("dir to oe");
   AST_SPI_OWN:
      assert property (i_spi_en |-> o_pa_oe[3:0] == i_spi_oe
         && o_pa_out[3:0] == i_spi_out) else $error("serial pins");
   AST_DL_CLK: assert property (i_dl_en |-> o_pc_oe == 2'h1)
      else $error("link port c enables");
   AST_PULL_INT: assert property (o_pc_pulldown == {i_dl_en, 1'b0})
      else $error("interrupt pull-down");
   AST_PD_PULL:
      assert property (i_dl_en && !i_dl_data_oe |->
         o_pd_pulldown == (i_dl_wide ? 8'hff : 8'h0f)) else $error("pd pull");
   AST_RED:
      assert property ($past(i_wr && i_addr == OFS_PA_DRV_RED) |->
         o_pa_drv_reduce == $past(i_wdata[PA_W-1:0])) else $error("reduce");
   COV_SPI: cover property (i_spi_en && |i_spi_oe);
   COV_NARROW: cover property (i_dl_en && !i_dl_wide);
   COV_RSVD: cover property (i_rd && rsvd);
endmodule
`default_nettype wire

// ==== sim/pib_pad.sv ====
`timescale 1ns/1ps
`default_nettype none
module pib_pad #(parameter int W = 8)
(
   input wire logic [W-1:0] i_out,
   input wire logic [W-1:0] i_oe,
   input wire logic [W-1:0] i_pd,
   input wire logic [W-1:0] i_ext,
   input wire logic [W-1:0] i_ext_oe,
   output logic [W-1:0] o_pin
);
   // A floating pin shows the inverse of the last outside drive
   always_comb
   begin
      for (int k = 0; k < W; k++)
      begin
         if (i_oe[k]) o_pin[k] = i_out[k];
         else if (i_ext_oe[k]) o_pin[k] = i_ext[k];
         else if (i_pd[k]) o_pin[k] = 1'b0;
         else o_pin[k] = ~i_ext[k];
      end
   end
endmodule
`default_nettype wire

// ==== sim/pib_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pib_top_test
   import pib_pkg::*;
;
   logic i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic i_spi_en = 1'b0, i_dl_en = 1'b0, i_dl_wide = 1'b0;
   logic i_dl_clk = 1'b0, i_dl_data_oe = 1'b0, o_dl_int;
   logic [ADDR_W-1:0] i_addr = 9'h000;
   logic [DATA_W-1:0] i_wdata = 8'h00, o_rdata;
   logic [SPI_W-1:0] i_spi_out = 4'h0, i_spi_oe = 4'h0, o_spi_in;
   logic [PA_W-1:0] i_pa_in, o_pa_out, o_pa_oe, o_pa_drv_reduce;
   logic [PA_W-1:0] ea = 6'h00, ea_oe = 6'h3f;
   logic [PC_W-1:0] i_pc_in, o_pc_out, o_pc_oe, o_pc_pulldown;
   logic [PC_W-1:0] ec = 2'h0, ec_oe = 2'h3;
   logic [PD_W-1:0] i_dl_data_out = 8'h00, o_dl_data_in, i_pd_in;
   logic [PD_W-1:0] o_pd_out, o_pd_oe, o_pd_pulldown;
   logic [PD_W-1:0] ed = 8'h00, ed_oe = 8'hff;
   int err_count = 0, n_checks = 0, cyc = 0;
   logic [ADDR_W-1:0] ofs [12] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004,
      9'h005, 9'h006, 9'h007, 9'h120, 9'h121, 9'h122, 9'h1ff};
   logic [DATA_W-1:0] msk [12] = '{8'h3f, 8'h00, 8'h3f, 8'h00, 8'h03,
      8'hff, 8'h03, 8'hff, 8'h3f, 8'h00, 8'h3f, 8'h00};

   pib_top dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_spi_en(i_spi_en), .i_spi_out(i_spi_out), .i_spi_oe(i_spi_oe),
      .o_spi_in(o_spi_in), .i_dl_en(i_dl_en), .i_dl_wide(i_dl_wide),
      .i_dl_clk(i_dl_clk), .i_dl_data_out(i_dl_data_out),
      .i_dl_data_oe(i_dl_data_oe), .o_dl_data_in(o_dl_data_in),
      .o_dl_int(o_dl_int), .i_pa_in(i_pa_in), .o_pa_out(o_pa_out),
      .o_pa_oe(o_pa_oe), .o_pa_drv_reduce(o_pa_drv_reduce),
      .i_pc_in(i_pc_in), .o_pc_out(o_pc_out), .o_pc_oe(o_pc_oe),
      .o_pc_pulldown(o_pc_pulldown), .i_pd_in(i_pd_in), .o_pd_out(o_pd_out),
      .o_pd_oe(o_pd_oe), .o_pd_pulldown(o_pd_pulldown));
   pib_pad #(.W(6)) pad_a (.i_out(o_pa_out), .i_oe(o_pa_oe), .i_pd(6'h00),
      .i_ext(ea), .i_ext_oe(ea_oe), .o_pin(i_pa_in));
   pib_pad #(.W(2)) pad_c (.i_out(o_pc_out), .i_oe(o_pc_oe),
      .i_pd(o_pc_pulldown), .i_ext(ec), .i_ext_oe(ec_oe), .o_pin(i_pc_in));
   pib_pad #(.W(8)) pad_d (.i_out(o_pd_out), .i_oe(o_pd_oe),
      .i_pd(o_pd_pulldown), .i_ext(ed), .i_ext_oe(ed_oe), .o_pin(i_pd_in));

   initial
   begin
      forever #25 i_clk = ~i_clk;
   end

   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         err_count++;
         summarize();
      end
   end

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe is taken
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask

   initial
   begin
      repeat (8) @(posedge i_clk);
      i_arst_n <= 1'b1;
      foreach (ofs[k])
      begin
         rd(ofs[k]);
         chk(o_rdata, 8'h00);
      end
      foreach (ofs[k])
         wr(ofs[k], 8'hff);
      // A reserved or read-only write that aliased a register would clear it
      foreach (ofs[k])
         if (msk[k] == 8'h00 || ofs[k] == OFS_PA_PIN_IN)
            wr(ofs[k], 8'h00);
      foreach (ofs[k])
      begin
         rd(ofs[k]);
         chk(o_rdata, msk[k]);
      end
      chk({2'h0, o_pa_drv_reduce}, 8'h3f);
      wr(OFS_PA_DATA, 8'h15);
      wr(OFS_PA_DIR, 8'h00);
      @(posedge i_clk);
      ea <= 6'h2a;
      w(8);
      rd(OFS_PA_DATA);
      chk(o_rdata, 8'h2a);
      rd(OFS_PA_PIN_IN);
      chk(o_rdata, 8'h2a);
      wr(OFS_PA_DIR, 8'h3f);
      rd(OFS_PA_DATA);
      chk(o_rdata, 8'h15);
      chk({2'h0, i_pa_in}, 8'h15);
      @(posedge i_clk);
      i_spi_en <= 1'b1;
      i_spi_oe <= 4'hb;
      i_spi_out <= 4'h6;
      w(1);
      chk({2'h0, i_pa_in}, 8'h12);
      rd(OFS_PA_DIR);
      chk(o_rdata, 8'h3f);
      @(posedge i_clk);
      i_spi_oe <= 4'h0;
      ea <= 6'h05;
      w(8);
      chk({4'h0, o_spi_in}, 8'h05);
      @(posedge i_clk);
      i_spi_en <= 1'b0;
      i_dl_en <= 1'b1;
      i_dl_wide <= 1'b1;
      i_dl_clk <= 1'b1;
      ed_oe <= 8'h00;
      ec_oe <= 2'h2;
      ec <= 2'h2;
      w(8);
      chk(i_pd_in, 8'h00);
      chk({6'h0, i_pc_in}, 8'h03);
      chk({7'h0, o_dl_int}, 8'h01);
      @(posedge i_clk);
      ed_oe <= 8'hff;
      ed <= 8'h5c;
      w(8);
      chk(o_dl_data_in, 8'h5c);
      @(posedge i_clk);
      i_dl_wide <= 1'b0;
      w(8);
      chk(o_dl_data_in, 8'h0c);
      @(posedge i_clk);
      i_dl_wide <= 1'b1;
      i_dl_data_oe <= 1'b1;
      i_dl_data_out <= 8'h96;
      w(1);
      chk(i_pd_in, 8'h96);
      summarize();
   end
endmodule

bind pib_top pib_top_asserts u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_spi_en(i_spi_en), .i_spi_out(i_spi_out),
   .i_spi_oe(i_spi_oe), .i_dl_en(i_dl_en), .i_dl_wide(i_dl_wide),
   .i_dl_data_oe(i_dl_data_oe), .o_pa_out(o_pa_out), .o_pa_oe(o_pa_oe),
   .o_pa_drv_reduce(o_pa_drv_reduce), .o_pc_oe(o_pc_oe),
   .o_pc_pulldown(o_pc_pulldown), .o_pd_pulldown(o_pd_pulldown));
`default_nettype wire
